// File: rtl/mte_top.sv
// mac lookup table and static address table with indirect entry access
module mte_top #(
	parameter int         LT_AW    = 12,
	parameter logic [2:0] AGE_INIT = 3'h7
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic [11:0]                 reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [31:0]                 reg_wdata,
	output logic [31:0]                      reg_rdata,
	input  wire logic                        age_tick,
	input  wire logic                        sa_valid,
	input  wire logic [mte_pkg::MAC_W-1:0]   sa_mac,
	input  wire logic [mte_pkg::VFG_W-1:0]   sa_vfg,
	input  wire logic [mte_pkg::STG_W-1:0]   sa_stg,
	input  wire logic [mte_pkg::FWD_W-1:0]   sa_port,
	output logic                             sa_done,
	output logic                             sa_drop,
	input  wire logic                        da_valid,
	input  wire logic [mte_pkg::MAC_W-1:0]   da_mac,
	input  wire logic [mte_pkg::VFG_W-1:0]   da_vfg,
	input  wire logic [mte_pkg::STG_W-1:0]   da_stg,
	output logic                             da_done,
	output logic                             da_hit,
	output logic                             da_static,
	output logic                             da_drop,
	output logic                             da_override,
	output logic [mte_pkg::FWD_W-1:0]        da_fwd,
	output logic [mte_pkg::PA_W-1:0]         da_prio
);
	import mte_pkg::*;

	localparam int LT_DEPTH = 1 << LT_AW;

	// ***********************************************************
	// state
	// ***********************************************************
	typedef struct packed {
		mte_state_e           st;
		mte_ent_s             ent;
		logic [ST_IDX_W-1:0]  st_idx;
		logic                 st_tsel;
		logic                 st_act;
		logic                 st_go;
		logic [LT_ACT_W-1:0]  lt_act;
		logic                 lt_go;
		logic                 lt_valid;
		logic [ST_DEPTH-1:0]  st_valid;
		logic [LT_AW-1:0]     ptr;
		logic                 age_req;
		logic [31:0]          rdata;
		logic                 sa_done;
		logic                 sa_drop;
		logic                 da_done;
		logic                 da_hit;
		logic                 da_static;
		logic                 da_drop;
		logic                 da_override;
		logic [FWD_W-1:0]     da_fwd;
		logic [PA_W-1:0]      da_prio;
	} mte_top_s;

	localparam mte_top_s RST = '{st: ST_CLR, ent: ENT_ZERO, default: '0};

	mte_top_s r;
	mte_top_s next_r;

	mte_ent_s lt_mem [LT_DEPTH];
	mte_ent_s st_mem [ST_DEPTH];

	logic                lt_we;
	logic [LT_AW-1:0]    lt_wa;
	mte_ent_s            lt_wd;
	logic                st_we;
	logic [ST_IDX_W-1:0] st_wi;
	mte_ent_s            st_wd;

	logic                sm_hit;
	logic [ST_IDX_W-1:0] sm_idx;

	// simple xor fold of address and filter group onto the index
	function automatic logic [LT_AW-1:0] lt_hash(input logic [MAC_W-1:0] mac,
		input logic [VFG_W-1:0] vfg);
		logic [LT_AW-1:0] h;
		h = LT_AW'(vfg);
		for (int i = 0; i < MAC_W; i++) begin
			h[i % LT_AW] = h[i % LT_AW] ^ mac[i];
		end
		return h;
	endfunction

	function automatic logic key_eq(input mte_ent_s e,
		input logic [MAC_W-1:0] mac, input logic [VFG_W-1:0] vfg);
		return mte_live(e) && e.mac == mac && e.vfg == vfg;
	endfunction

	// ***********************************************************
	// static table compare
	// ***********************************************************
	// static table searched
	mte_static_match #(
		.DEPTH (ST_DEPTH),
		.IW    (ST_IDX_W)
	) u_match (
		.entries (st_mem),
		.valid   (r.st_valid),
		.mac     (da_mac),
		.vfg     (da_vfg),
		.stg     (da_stg),
		.hit     (sm_hit),
		.idx     (sm_idx)
	);

	// ***********************************************************
	// next state
	// ***********************************************************
	always_comb begin
		mte_ent_s        e_sa;
		mte_ent_s        e_da;
		mte_ent_s        e_op;
		mte_ent_s        e_age;
		mte_ent_s        e_st;
		logic [LT_AW-1:0] i_sa;
		logic [LT_AW-1:0] i_op;
		logic            sa_hit;
		logic            lt_hit;
		logic            learn_ok;
		i_sa = lt_hash(sa_mac, sa_vfg);
		i_op = lt_hash(r.ent.mac, r.ent.vfg);
		e_sa = lt_mem[i_sa];
		e_da = lt_mem[lt_hash(da_mac, da_vfg)];
		e_op = lt_mem[i_op];
		e_age = lt_mem[r.ptr];
		e_st = st_mem[sm_idx];
		sa_hit = key_eq(e_sa, sa_mac, sa_vfg);
		lt_hit = key_eq(e_da, da_mac, da_vfg) && e_da.stg == da_stg;
		learn_ok = (r.st == ST_IDLE) || (r.st == ST_AGE);
		next_r = r;
		next_r.sa_done = 1'b0;
		next_r.da_done = 1'b0;
		lt_we = 1'b0;
		lt_wa = '0;
		lt_wd = ENT_ZERO;
		st_we = 1'b0;
		st_wi = '0;
		st_wd = ENT_ZERO;

		// source side: drop check, age refresh and learning
		if (sa_valid) begin
			next_r.sa_done = 1'b1;
			next_r.sa_drop = sa_hit && e_sa.src_drop;
			if (learn_ok) begin
				if (sa_hit && !e_sa.flag) begin
					lt_we = 1'b1;
					lt_wa = i_sa;
					lt_wd = e_sa;
					lt_wd.prio_age = AGE_INIT;
				// static slot never replaced by learning
				end else if (!sa_hit && !(mte_live(e_sa) && e_sa.flag)) begin
					lt_we = 1'b1;
					lt_wa = i_sa;
					lt_wd = ENT_ZERO;
					lt_wd.prio_age = AGE_INIT;
					lt_wd.stg = sa_stg;
					lt_wd.fwd = sa_port;
					lt_wd.vfg = sa_vfg;
					lt_wd.mac = sa_mac;
				end
			end
		end

		// destination side
		if (da_valid) begin
			next_r.da_done = 1'b1;
			next_r.da_hit = sm_hit | lt_hit;
			next_r.da_static = sm_hit | (lt_hit & e_da.flag);
			if (sm_hit) begin
				next_r.da_drop = e_st.dst_drop;
				next_r.da_override = e_st.override;
				next_r.da_fwd = e_st.fwd;
				next_r.da_prio = e_st.prio_age;
			end else if (lt_hit) begin
				next_r.da_drop = e_da.dst_drop;
				next_r.da_override = e_da.override;
				next_r.da_fwd = e_da.fwd;
				next_r.da_prio = e_da.flag ? e_da.prio_age : PA_ZERO;
			end else begin
				next_r.da_drop = 1'b0;
				next_r.da_override = 1'b0;
				next_r.da_fwd = '0;
				next_r.da_prio = PA_ZERO;
			end
		end

		case (r.st)
			ST_CLR: begin
				lt_we = 1'b1;
				lt_wa = r.ptr;
				lt_wd = ENT_ZERO;
				next_r.ptr = LT_AW'(r.ptr + 1'b1);
				if (r.ptr == {LT_AW{1'b1}}) begin
					next_r.st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (r.st_go) begin
					next_r.st = ST_STAT;
				end else if (r.lt_go) begin
					next_r.st = ST_LT;
				end else if (r.age_req) begin
					next_r.age_req = 1'b0;
					next_r.ptr = '0;
					next_r.st = ST_AGE;
				end
			end
			ST_STAT: begin
				// select zero is the static table
				if (r.st_tsel == TSEL_STATIC) begin
					if (r.st_act == ST_ACT_WR) begin
						st_we = 1'b1;
						st_wi = r.st_idx;
						st_wd = r.ent;
						next_r.st_valid[r.st_idx] = r.ent.flag;
					end else begin
						next_r.ent = st_mem[r.st_idx];
						next_r.ent.flag = r.st_valid[r.st_idx];
					end
				end
				next_r.st_go = 1'b0;
				next_r.st = ST_IDLE;
			end
			ST_LT: begin
				if (r.lt_act == LT_ACT_READ) begin
					if (key_eq(e_op, r.ent.mac, r.ent.vfg)) begin
						next_r.ent = e_op;
						next_r.lt_valid = 1'b1;
					end else begin
						next_r.ent = ENT_ZERO;
						next_r.lt_valid = 1'b0;
					end
				end else if (r.lt_act == LT_ACT_WRITE) begin
					lt_we = r.ent.flag;
					lt_wa = i_op;
					lt_wd = r.ent;
					next_r.lt_valid = r.ent.flag;
				end
				next_r.lt_go = 1'b0;
				next_r.st = ST_IDLE;
			end
			ST_AGE: begin
				// a learning write this cycle takes the port; retry here
				if (!lt_we) begin
					if (!e_age.flag && e_age.prio_age != PA_ZERO) begin
						lt_we = 1'b1;
						lt_wa = r.ptr;
						lt_wd = e_age;
						lt_wd.prio_age = PA_W'(e_age.prio_age - PA_ONE);
					end
					next_r.ptr = LT_AW'(r.ptr + 1'b1);
					if (r.ptr == {LT_AW{1'b1}}) begin
						next_r.st = ST_IDLE;
					end
				end
			end
			default: begin
				next_r.st = ST_IDLE;
			end
		endcase

		// a new aging request beats the clear on entry
		if (age_tick) begin
			next_r.age_req = 1'b1;
		end

		// host writes last, so a new go wins over completion
		if (reg_wr) begin
			case (reg_addr)
				OFS_WORD1: begin
					next_r.ent.flag = reg_wdata[W1_FLAG_BIT];
					next_r.ent.src_drop = reg_wdata[W1_SRC_BIT];
					next_r.ent.dst_drop = reg_wdata[W1_DST_BIT];
					next_r.ent.prio_age = reg_wdata[W1_PA_LSB +: PA_W];
					next_r.ent.stg = reg_wdata[W1_STG_LSB +: STG_W];
				end
				OFS_WORD2: begin
					next_r.ent.override = reg_wdata[W2_OVR_BIT];
					next_r.ent.fwd = reg_wdata[W2_FWD_LSB +: FWD_W];
				end
				OFS_WORD3: begin
					next_r.ent.vfg = reg_wdata[W3_VFG_LSB +: VFG_W];
					next_r.ent.mac[MAC_W-1:MACL_W] =
						reg_wdata[W3_MACH_LSB +: MACH_W];
				end
				OFS_WORD4: begin
					next_r.ent.mac[MACL_W-1:0] =
						reg_wdata[W4_MACL_LSB +: MACL_W];
				end
				OFS_ST_CTRL: begin
					next_r.st_idx = reg_wdata[ST_IDX_LSB +: ST_IDX_W];
					next_r.st_tsel = reg_wdata[ST_TSEL_BIT];
					next_r.st_act = reg_wdata[ST_ACT_BIT];
					next_r.st_go = reg_wdata[CT_GO_BIT];
				end
				OFS_LT_CTRL: begin
					next_r.lt_act = reg_wdata[LT_ACT_LSB +: LT_ACT_W];
					next_r.lt_go = reg_wdata[CT_GO_BIT];
				end
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			next_r.rdata = '0;
			case (reg_addr)
				OFS_WORD1: next_r.rdata = mte_word(r.ent, 2'h0);
				OFS_WORD2: next_r.rdata = mte_word(r.ent, 2'h1);
				OFS_WORD3: next_r.rdata = mte_word(r.ent, 2'h2);
				OFS_WORD4: next_r.rdata = mte_word(r.ent, 2'h3);
				OFS_ST_CTRL: begin
					next_r.rdata[ST_IDX_LSB +: ST_IDX_W] = r.st_idx;
					next_r.rdata[ST_TSEL_BIT] = r.st_tsel;
					next_r.rdata[ST_ACT_BIT] = r.st_act;
					next_r.rdata[CT_GO_BIT] = r.st_go;
				end
				OFS_LT_CTRL: begin
					next_r.rdata[LT_ACT_LSB +: LT_ACT_W] = r.lt_act;
					next_r.rdata[LT_VALID_BIT] = r.lt_valid;
					next_r.rdata[CT_GO_BIT] = r.lt_go;
				end
				default: next_r.rdata = '0;
			endcase
		end
	end

	// ***********************************************************
	// registers
	// ***********************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= RST;
		end else begin
			r <= next_r;
		end
	end

	// tables carry no reset; the clear walk and valid bits cover them
	always_ff @(posedge clk) begin
		if (lt_we) begin
			lt_mem[lt_wa] <= lt_wd;
		end
		if (st_we) begin
			st_mem[st_wi] <= st_wd;
		end
	end

	assign reg_rdata = r.rdata;
	assign sa_done = r.sa_done;
	assign sa_drop = r.sa_drop;
	assign da_done = r.da_done;
	assign da_hit = r.da_hit;
	assign da_static = r.da_static;
	assign da_drop = r.da_drop;
	assign da_override = r.da_override;
	assign da_fwd = r.da_fwd;
	assign da_prio = r.da_prio;

endmodule

// File: inc/mte_pkg.sv
// constants, entry layout and states for the mac table entry access block
package mte_pkg;

	// ***********************************************************
	// register offsets
	// ***********************************************************
	localparam logic [11:0] OFS_LT_CTRL = 12'h418;
	localparam logic [11:0] OFS_ST_CTRL = 12'h41C;
	localparam logic [11:0] OFS_WORD1   = 12'h420;
	localparam logic [11:0] OFS_WORD2   = 12'h424;
	localparam logic [11:0] OFS_WORD3   = 12'h428;
	localparam logic [11:0] OFS_WORD4   = 12'h42C;

	// ***********************************************************
	// field widths and positions
	// ***********************************************************
	localparam int PA_W     = 3;
	localparam int STG_W    = 3;
	localparam int FWD_W    = 3;
	localparam int VFG_W    = 7;
	localparam int MAC_W    = 48;
	localparam int MACH_W   = 16;
	localparam int MACL_W   = 32;
	localparam int ST_IDX_W = 4;
	localparam int ST_DEPTH = 16;
	localparam int LT_ACT_W = 2;

	localparam int W1_FLAG_BIT = 31;
	localparam int W1_SRC_BIT  = 30;
	localparam int W1_DST_BIT  = 29;
	localparam int W1_PA_LSB   = 26;
	localparam int W1_STG_LSB  = 0;
	localparam int W2_OVR_BIT  = 31;
	localparam int W2_FWD_LSB  = 0;
	localparam int W3_VFG_LSB  = 16;
	localparam int W3_MACH_LSB = 0;
	localparam int W4_MACL_LSB = 0;

	localparam int CT_GO_BIT     = 31;
	localparam int ST_IDX_LSB    = 0;
	localparam int ST_TSEL_BIT   = 8;
	localparam int ST_ACT_BIT    = 9;
	localparam int LT_ACT_LSB    = 0;
	localparam int LT_VALID_BIT  = 8;

	// ***********************************************************
	// command codes
	// ***********************************************************
	localparam logic [1:0] LT_ACT_WRITE = 2'h1;
	localparam logic [1:0] LT_ACT_READ  = 2'h2;
	localparam logic       ST_ACT_WR    = 1'h0;
	localparam logic       TSEL_STATIC  = 1'h0;
	localparam logic [2:0] PA_ONE       = 3'h1;
	localparam logic [2:0] PA_ZERO      = 3'h0;

	// ***********************************************************
	// entry layout and states
	// ***********************************************************
	typedef struct packed {
		logic              flag;
		logic              src_drop;
		logic              dst_drop;
		logic [PA_W-1:0]   prio_age;
		logic [STG_W-1:0]  stg;
		logic              override;
		logic [FWD_W-1:0]  fwd;
		logic [VFG_W-1:0]  vfg;
		logic [MAC_W-1:0]  mac;
	} mte_ent_s;

	localparam mte_ent_s ENT_ZERO = '0;

	typedef enum logic [4:0] {
		ST_CLR  = 5'h01,
		ST_IDLE = 5'h02,
		ST_STAT = 5'h04,
		ST_LT   = 5'h08,
		ST_AGE  = 5'h10
	} mte_state_e;

	// entry word as software sees it; unused bits are zero
	function automatic logic [31:0] mte_word(input mte_ent_s e,
		input logic [1:0] sel);
		logic [31:0] w;
		w = '0;
		case (sel)
			2'h0: begin
				w[W1_FLAG_BIT] = e.flag;
				w[W1_SRC_BIT] = e.src_drop;
				w[W1_DST_BIT] = e.dst_drop;
				w[W1_PA_LSB +: PA_W] = e.prio_age;
				w[W1_STG_LSB +: STG_W] = e.stg;
			end
			2'h1: begin
				w[W2_OVR_BIT] = e.override;
				w[W2_FWD_LSB +: FWD_W] = e.fwd;
			end
			2'h2: begin
				w[W3_VFG_LSB +: VFG_W] = e.vfg;
				w[W3_MACH_LSB +: MACH_W] = e.mac[MAC_W-1:MACL_W];
			end
			default: begin
				w[W4_MACL_LSB +: MACL_W] = e.mac[MACL_W-1:0];
			end
		endcase
		return w;
	endfunction

	// a dynamic entry with zero age is stale
	function automatic logic mte_live(input mte_ent_s e);
		return e.flag | (e.prio_age != PA_ZERO);
	endfunction

endpackage

// File: rtl/mte_static_match.sv
// parallel compare of a destination key against the static address table
module mte_static_match #(
	parameter int DEPTH = 16,
	parameter int IW    = 4
) (
	input  mte_pkg::mte_ent_s          entries [DEPTH],
	input  wire logic [DEPTH-1:0]      valid,
	input  wire logic [mte_pkg::MAC_W-1:0] mac,
	input  wire logic [mte_pkg::VFG_W-1:0] vfg,
	input  wire logic [mte_pkg::STG_W-1:0] stg,
	output logic                       hit,
	output logic [IW-1:0]              idx
);
	import mte_pkg::*;

	// lowest matching index wins if software loaded duplicates
	always_comb begin
		hit = 1'b0;
		idx = '0;
		for (int i = DEPTH - 1; i >= 0; i--) begin
			if (valid[i] && entries[i].mac == mac &&
				entries[i].vfg == vfg && entries[i].stg == stg) begin
				hit = 1'b1;
				idx = IW'(i);
			end
		end
	end

endmodule

// File: testbench/mte_chk_sva.sv
// port-level checks for the mac table entry access block
module mte_chk
	import mte_pkg::*;
(
	input wire logic                        clk,
	input wire logic                        rst_n,
	input wire logic [11:0]                 reg_addr,
	input wire logic                        reg_rd,
	input wire logic [31:0]                 reg_rdata,
	input wire logic                        sa_valid,
	input wire logic                        sa_done,
	input wire logic                        sa_drop,
	input wire logic                        da_valid,
	input wire logic                        da_done,
	input wire logic                        da_hit,
	input wire logic                        da_static,
	input wire logic                        da_drop,
	input wire logic                        da_override,
	input wire logic [mte_pkg::FWD_W-1:0]   da_fwd,
	input wire logic [mte_pkg::PA_W-1:0]    da_prio
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_rd(logic [11:0] a);
		reg_rd && reg_addr == a;
	endsequence

	a_rsvd_word1: assert property (s_rd(OFS_WORD1) |=> reg_rdata[25:3] == '0)
		else $error("word1 reserved bits set");
	a_rsvd_word2: assert property (s_rd(OFS_WORD2) |=> reg_rdata[30:3] == '0)
		else $error("word2 reserved bits set");
	a_rsvd_word3: assert property (s_rd(OFS_WORD3) |=> reg_rdata[31:23] == '0)
		else $error("word3 reserved bits set");
	a_unmapped_zero: assert property (s_rd(12'h430) |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_da_answer: assert property (da_valid |=> da_done)
		else $error("lookup not answered");
	a_da_pulse: assert property (!da_valid |=> !da_done)
		else $error("lookup done without request");
	a_sa_answer: assert property (sa_valid |=> sa_done)
		else $error("source lookup not answered");
	a_static_hit: assert property (da_static |-> da_hit)
		else $error("static flag without hit");
	a_miss_clean: assert property (da_done && !da_hit |->
		{da_drop, da_override, da_fwd, da_prio} == '0)
		else $error("miss carries result fields");
	a_dyn_prio: assert property (da_hit && !da_static |-> da_prio == PA_ZERO)
		else $error("dynamic hit with priority");
	a_drop_hold: assert property (!sa_done |-> $stable(sa_drop))
		else $error("source drop moved");
endmodule

// File: testbench/mte_host.sv
// host processor model driving the register strobes
module mte_host (
	input  wire logic        clk,
	input  wire logic [31:0] reg_rdata,
	output logic [11:0]      reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [31:0]      reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
	end
	// released bus shows inverted values, not the last ones
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic go(input logic [11:0] a, input logic [31:0] c,
		output logic busy);
		logic [31:0] d;
		int n;
		wr(a, c);
		n = 0;
		do begin
			rd(a, d);
			n++;
		end while (d[mte_pkg::CT_GO_BIT] !== 1'b0 && n < 60);
		busy = d[mte_pkg::CT_GO_BIT];
	endtask
endmodule

// File: testbench/mte_top_test.sv
// self-checking bench for the mac table entry access block
module mte_top_test;
	import mte_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [47:0] MAC_A = 48'hABCD_12345678;
	localparam logic [47:0] MAC_3 = 48'h0001_00000003;
	localparam logic [31:0] MSK [4] = '{32'hFC000007, 32'h80000007,
		32'h007FFFFF, 32'hFFFFFFFF};
	localparam logic [31:0] ENT_A [4] = '{32'hB4000002, 32'h80000005,
		32'h0011ABCD, 32'h12345678};
	logic        clk, rst_n, age_tick, sa_valid, da_valid, reg_wr, reg_rd;
	logic        sa_done, sa_drop, da_done, da_hit, da_static, da_drop;
	logic        da_override;
	logic [47:0] sa_mac, da_mac;
	logic [6:0]  sa_vfg, da_vfg;
	logic [2:0]  sa_stg, sa_port, da_stg, da_fwd, da_prio;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	int          n_fail = 0;
	int          checks = 0;
	int          cyc = 0;

	mte_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
	mte_top #(.LT_AW(4)) DUT (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .age_tick(age_tick),
		.sa_valid(sa_valid), .sa_mac(sa_mac), .sa_vfg(sa_vfg),
		.sa_stg(sa_stg), .sa_port(sa_port), .sa_done(sa_done),
		.sa_drop(sa_drop), .da_valid(da_valid), .da_mac(da_mac),
		.da_vfg(da_vfg), .da_stg(da_stg), .da_done(da_done),
		.da_hit(da_hit), .da_static(da_static), .da_drop(da_drop),
		.da_override(da_override), .da_fwd(da_fwd), .da_prio(da_prio));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// ***********************************************************
	// compares and transfers
	// ***********************************************************
	task automatic close_out();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk32(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_da(input logic [10:0] e);
		checks++;
		if ({da_done, da_hit, da_static, da_drop, da_override, da_fwd,
			da_prio} !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, {da_done,
				da_hit, da_static, da_drop, da_override, da_fwd, da_prio}, e);
		end
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		host.rd(a, d);
		chk32(d, e);
	endtask
	task automatic wr4(input logic [31:0] w [4]);
		for (int i = 0; i < 4; i++)
			host.wr(OFS_WORD1 + 12'(4 * i), w[i]);
	endtask
	task automatic op(input logic [11:0] a, input logic [31:0] c);
		logic b;
		host.go(a, c, b);
		chk32({31'h0, b}, 32'h0);
	endtask
	task automatic da(input logic [47:0] m, input logic [6:0] v,
		input logic [2:0] s, input logic [10:0] e);
		@(posedge clk);
		da_valid <= 1'b1;
		da_mac <= m;
		da_vfg <= v;
		da_stg <= s;
		@(posedge clk);
		da_valid <= 1'b0;
		da_mac <= ~m;
		@(negedge clk);
		chk_da(e);
	endtask
	task automatic sa(input logic [47:0] m, input logic [6:0] v,
		input logic [2:0] p);
		@(posedge clk);
		sa_valid <= 1'b1;
		sa_mac <= m;
		sa_vfg <= v;
		sa_stg <= 3'h2;
		sa_port <= p;
		@(posedge clk);
		sa_valid <= 1'b0;
		sa_mac <= ~m;
		@(negedge clk);
	endtask
	task automatic age();
		@(posedge clk);
		age_tick <= 1'b1;
		@(posedge clk);
		age_tick <= 1'b0;
		repeat (20) @(posedge clk);
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	// ***********************************************************
	// main sequence
	// ***********************************************************
	initial begin
		{rst_n, age_tick, sa_valid, da_valid} = '0;
		{sa_mac, sa_vfg, sa_stg, sa_port} = '0;
		{da_mac, da_vfg, da_stg} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (20) @(posedge clk);
		wr4('{'1, '1, '1, '1});
		for (int i = 0; i < 4; i++)
			rd_chk(OFS_WORD1 + 12'(4 * i), MSK[i]);
		rd_chk(12'h430, 32'h0);
		wr4(ENT_A);
		op(OFS_ST_CTRL, 32'h8000000F);
		wr4('{'0, '0, '0, '0});
		op(OFS_ST_CTRL, 32'h8000020F);
		for (int i = 0; i < 4; i++)
			rd_chk(OFS_WORD1 + 12'(4 * i), ENT_A[i]);
		wr4('{32'h14000000, 32'h1, 32'h00114444, 32'h44444444});
		op(OFS_ST_CTRL, 32'h80000003);
		da(48'h4444_44444444, 7'h11, 3'h0, 11'h400);
		sa(MAC_A, 7'h11, 3'h1);
		da(MAC_A, 7'h11, 3'h2, 11'h7ED);
		da(MAC_A, 7'h11, 3'h3, 11'h400);
		sa(48'h42, 7'h0, 3'h2);
		chk32({31'h0, sa_drop}, 32'h0);
		da(48'h42, 7'h0, 3'h2, 11'h610);
		wr4('{'0, '0, '0, 32'h42});
		op(OFS_LT_CTRL, 32'h80000002);
		rd_chk(OFS_WORD1, 32'h1C000002);
		host.rd(OFS_LT_CTRL, d);
		chk32(d & 32'h100, 32'h100);
		repeat (7) age();
		da(48'h42, 7'h0, 3'h2, 11'h400);
		op(OFS_LT_CTRL, 32'h80000002);
		for (int i = 0; i < 4; i++)
			rd_chk(OFS_WORD1 + 12'(4 * i), 32'h0);
		wr4('{32'hCC000000, 32'h2, 32'h00220001, 32'h3});
		op(OFS_LT_CTRL, 32'h80000001);
		sa(MAC_3, 7'h22, 3'h1);
		chk32({31'h0, sa_drop}, 32'h1);
		repeat (4) age();
		da(MAC_3, 7'h22, 3'h0, 11'h713);
		da(MAC_A, 7'h11, 3'h2, 11'h7ED);
		wr4('{32'h0C000000, 32'h1, 32'h00330005, 32'h5});
		op(OFS_LT_CTRL, 32'h80000001);
		host.rd(OFS_LT_CTRL, d);
		chk32(d & 32'h100, 32'h0);
		da(48'h0005_00000005, 7'h33, 3'h0, 11'h400);
		close_out();
	end
endmodule

bind mte_top mte_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sa_valid(sa_valid),
	.sa_done(sa_done), .sa_drop(sa_drop), .da_valid(da_valid),
	.da_done(da_done), .da_hit(da_hit), .da_static(da_static),
	.da_drop(da_drop), .da_override(da_override), .da_fwd(da_fwd),
	.da_prio(da_prio));
